// file: hdl/rsb_pkg.sv
/*
 * Shared constants and types for the reset strap capture and boot select block.
 * Assumes a single core clock domain; strap and host pins arrive synchronous to it.
 */
package rsb_pkg;

   localparam logic [1:0] BOOT_HOST_NO_PLL = 2'h0;
   localparam logic [1:0] BOOT_I2C = 2'h1;
   localparam logic [1:0] BOOT_HOST_PLL = 2'h2;
   localparam logic [1:0] BOOT_RSVD = 2'h3;

   localparam int GROUP_WORDS = 4;
   localparam int HOST_WORD_W = 16;
   localparam int HOST_BYTE_W = 8;

   typedef struct packed {
      logic [1:0] boot_src;
      logic wdog_en;
      logic strobe_hi;
      logic width8;
      logic strobe_style;
   } rsb_straps_t;

   localparam rsb_straps_t STRAPS_RST = '{boot_src: BOOT_HOST_NO_PLL, default: 1'b0};

   typedef enum logic [2:0] {
      ST_RESET,
      ST_HOST,
      ST_I2C,
      ST_HALT,
      ST_RUN
   } rsb_state_t;

endpackage

// file: hdl/rsb_strap_latch.sv
/*
 * Strap latch: catches the configuration straps on the rising edge of power-on reset.
 * Assumes power_on_reset_n and the strap pins are synchronous to core_clk.
 */
`timescale 1ns/100ps
`default_nettype none
module rsb_strap_latch
   import rsb_pkg::*;
(
   input wire logic core_clk,             // Core clock
   input wire logic srst,                 // Synchronous reset, active high
   input wire logic power_on_reset_n,     // Power-on reset pin, active low
   input wire rsb_straps_t strap_pins,    // Raw strap pin levels
   output rsb_straps_t straps,            // Captured straps
   output logic captured                  // Pulse on the capture cycle
);

   logic por_prev_reg;
   rsb_straps_t straps_reg;
   logic captured_reg;
   wire logic por_rise;

   // Prev starts at 0 so a pin already high at srst release still captures once
   assign por_rise = power_on_reset_n & ~por_prev_reg;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         por_prev_reg <= 1'b0;
         straps_reg <= STRAPS_RST;
         captured_reg <= 1'b0;
      end else begin
         por_prev_reg <= power_on_reset_n;
         captured_reg <= por_rise;
         if (por_rise) begin
            straps_reg <= strap_pins;
         end
      end
   end

   assign straps = straps_reg;
   assign captured = captured_reg;

   strap_take_a: assert property (@(posedge core_clk) disable iff (srst)
      por_rise |=> straps_reg == $past(strap_pins))
      else $error("straps not taken at power-on reset release");
   strap_hold_a: assert property (@(posedge core_clk) disable iff (srst)
      !por_rise |=> $stable(straps_reg))
      else $error("straps changed outside power-on reset release");

endmodule
`default_nettype wire

// file: hdl/rsb_boot_ctrl.sv
/*
 * Boot controller: holds reset, picks the boot path from captured straps, keeps the
 * PLL bypassed until allowed, and gathers host port boot data into groups.
 * Assumes all inputs are synchronous to core_clk and the boot loader signals completion.
 */
//
// Contract
// - Latch boot source, watchdog, strobe polarity, width straps at POR rise.
// - Boot source 00 host no PLL, 01 I2C, 10 host with PLL, 11 reserved.
// - Strobe strap 1 means active high strobes, 0 active low.
// - Width strap 1 means 8-bit host path, 0 means 16-bit.
// - After power-on reset the PLL stays bypassed, clock from input pin.
// - PLL may switch on only after the ROM boot loader finished.
// - Host boot runs without DMA, polled on both sides.
// - Host straps taken only at POR release; hard reset keeps them.
// - Host data bit 0 is the least significant bit.
// - I2C boot moves shared pins to I2C, device acts as master.
`timescale 1ns/100ps
`default_nettype none
module rsb_boot_ctrl
   import rsb_pkg::*;
#(
   parameter int WORDS_PER_GROUP = GROUP_WORDS,
   parameter int WORD_W = HOST_WORD_W
) (
   input wire logic core_clk,                        // Core clock, 40 MHz
   input wire logic srst,                            // Synchronous reset, active high
   input wire logic power_on_reset_n,                // Power-on reset, active low
   input wire logic hard_reset_n,                    // Hard reset, active low
   input wire logic [1:0] boot_source_select,        // Boot source strap pins
   input wire logic watchdog_strap,                  // Watchdog enable strap
   input wire logic host_strobe_polarity,            // Strobe polarity strap
   input wire logic host_width_select,               // Host width strap
   input wire logic host_strobe_style,               // Strobe style strap
   input wire logic [WORD_W-1:0] host_parallel_port, // Host data pins
   input wire logic host_strobe_pin,                 // Host write strobe pin
   input wire logic loader_done,                     // Boot loader finished
   input wire logic pll_enable_req,                  // Software asks for the PLL
   input wire logic group_ack,                       // Loader consumed the group
   output logic core_in_reset,                       // Core held in reset
   output logic core_running,                        // Boot done, user code runs
   output logic watchdog_enable,                     // Watchdog timer enabled
   output logic host_strobe_high,                    // Strobes active high
   output logic host_8bit,                           // Host port 8-bit mode
   output logic host_strobe_dual,                    // Strobe style as strapped
   output logic pll_bypass,                          // PLL bypassed
   output logic host_polled_mode,                    // Host port polled, no DMA
   output logic host_dma_enable,                     // Host port DMA enable
   output logic host_rx_full,                        // Host must wait before writing
   output logic [WORDS_PER_GROUP*WORD_W-1:0] group_data, // Assembled boot group
   output logic group_ready,                         // Group waits for the loader
   output logic i2c_pins_select,                     // Shared pins set to I2C
   output logic i2c_master,                          // I2C block in master mode
   output logic boot_reserved_err                    // Reserved boot source strapped
);

   localparam int GW = WORDS_PER_GROUP * WORD_W;
   localparam int CNT_W = $clog2(2 * WORDS_PER_GROUP);
   localparam logic [CNT_W-1:0] LAST_WORD = CNT_W'(WORDS_PER_GROUP - 1);
   localparam logic [CNT_W-1:0] LAST_BYTE = CNT_W'(2 * WORDS_PER_GROUP - 1);
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

   // Elaboration check: byte and word packing assume a 16-bit host word
   if (WORD_W != HOST_WORD_W || WORDS_PER_GROUP < 1) begin
      $error("rsb_boot_ctrl: unsupported host word width or group size");
   end

   function automatic logic strobe_on(input logic pin, input logic active_high);
      return active_high ? pin : ~pin;
   endfunction

   function automatic logic [GW-1:0] shift_in(input logic [GW-1:0] acc,
         input logic [WORD_W-1:0] d, input logic w8);
      // Earlier pieces move up, so the first word ends most significant
      return w8 ? {acc[GW-HOST_BYTE_W-1:0], d[HOST_BYTE_W-1:0]} :
                  {acc[GW-WORD_W-1:0], d};
   endfunction

   rsb_straps_t strap_pins;
   rsb_straps_t straps;
   rsb_state_t state_reg, state_next;
   logic strobe_prev_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [GW-1:0] acc_reg;
   logic [GW-1:0] group_reg;
   logic group_ready_reg;
   logic pll_bypass_reg;
   logic in_reset_reg;
   logic polled_reg;
   logic i2c_sel_reg;
   logic i2c_master_reg;
   logic run_reg;
   logic halt_reg;

   assign strap_pins = '{boot_src: boot_source_select, wdog_en: watchdog_strap,
                         strobe_hi: host_strobe_polarity, width8: host_width_select,
                         strobe_style: host_strobe_style};

   rsb_strap_latch u_latch (
      .core_clk(core_clk),
      .srst(srst),
      .power_on_reset_n(power_on_reset_n),
      .strap_pins(strap_pins),
      .straps(straps),
      .captured()
   );

   wire logic in_reset;
   wire logic strobe_act;
   wire logic take;
   wire logic piece_last;
   wire logic [GW-1:0] acc_shift;
   wire logic pll_on;
   wire logic boot_go;

   // Hard reset restarts the boot but never reaches the strap latch
   assign in_reset = ~power_on_reset_n | ~hard_reset_n;
   // Leave reset one edge late, so the decode sees the straps captured at release
   assign boot_go = ~in_reset & ~in_reset_reg;
   assign strobe_act = strobe_on(host_strobe_pin, straps.strobe_hi);
   // Writes while a group is pending are dropped; the host polls host_rx_full
   assign take = strobe_act & ~strobe_prev_reg & (state_reg == ST_HOST)
                 & ~group_ready_reg;
   assign piece_last = cnt_reg == (straps.width8 ? LAST_BYTE : LAST_WORD);
   assign acc_shift = shift_in(acc_reg, host_parallel_port, straps.width8);
   assign pll_on = ((state_reg == ST_RUN) & pll_enable_req)
                   | ((state_reg == ST_HOST) & loader_done
                      & (straps.boot_src == BOOT_HOST_PLL));

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_RESET: begin
            if (boot_go) begin
               unique case (straps.boot_src)
                  BOOT_HOST_NO_PLL: state_next = ST_HOST;
                  BOOT_HOST_PLL: state_next = ST_HOST;
                  BOOT_I2C: state_next = ST_I2C;
                  BOOT_RSVD: state_next = ST_HALT;
               endcase
            end
         end
         ST_HOST: begin
            if (loader_done) begin
               state_next = ST_RUN;
            end
         end
         ST_I2C: begin
            if (loader_done) begin
               state_next = ST_RUN;
            end
         end
         ST_HALT: state_next = ST_HALT;
         ST_RUN: state_next = ST_RUN;
      endcase
      if (in_reset) begin
         state_next = ST_RESET;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_reg <= ST_RESET;
         in_reset_reg <= 1'b1;
         run_reg <= 1'b0;
         halt_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         in_reset_reg <= in_reset;
         run_reg <= state_next == ST_RUN;
         halt_reg <= state_next == ST_HALT;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst || in_reset) begin
         pll_bypass_reg <= 1'b1;
      end else if (pll_on) begin
         pll_bypass_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst || in_reset) begin
         polled_reg <= 1'b0;
         i2c_sel_reg <= 1'b0;
         i2c_master_reg <= 1'b0;
      end else begin
         polled_reg <= state_next == ST_HOST;
         if (state_next == ST_I2C) begin
            i2c_sel_reg <= 1'b1;
            i2c_master_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst || in_reset) begin
         strobe_prev_reg <= 1'b0;
         cnt_reg <= '0;
         acc_reg <= '0;
      end else begin
         strobe_prev_reg <= strobe_act;
         if (take) begin
            acc_reg <= piece_last ? '0 : acc_shift;
            cnt_reg <= piece_last ? '0 : cnt_reg + CNT_ONE;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst || in_reset) begin
         group_reg <= '0;
         group_ready_reg <= 1'b0;
      end else if (take && piece_last) begin
         group_reg <= acc_shift;
         group_ready_reg <= 1'b1;
      end else if (group_ack) begin
         group_ready_reg <= 1'b0;
      end
   end

   assign core_in_reset = in_reset_reg;
   assign core_running = run_reg;
   assign watchdog_enable = straps.wdog_en;
   assign host_strobe_high = straps.strobe_hi;
   assign host_8bit = straps.width8;
   assign host_strobe_dual = straps.strobe_style;
   assign pll_bypass = pll_bypass_reg;
   assign host_polled_mode = polled_reg;
   assign host_dma_enable = 1'b0;
   assign host_rx_full = group_ready_reg;
   assign group_data = group_reg;
   assign group_ready = group_ready_reg;
   assign i2c_pins_select = i2c_sel_reg;
   assign i2c_master = i2c_master_reg;
   assign boot_reserved_err = halt_reg;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);

   boot_decode_a: assert property (
      state_reg == ST_RESET && boot_go |=>
         (state_reg == ST_I2C) == ($past(straps.boot_src) == BOOT_I2C)
         && (state_reg == ST_HALT) == ($past(straps.boot_src) == BOOT_RSVD))
      else $error("boot source decoded wrongly");
   pll_reset_a: assert property ($past(in_reset) |-> pll_bypass_reg)
      else $error("PLL not bypassed after reset");
   pll_after_boot_a: assert property ($fell(pll_bypass_reg) |->
      $past(state_reg) == ST_RUN
      || ($past(state_reg) == ST_HOST && straps.boot_src == BOOT_HOST_PLL))
      else $error("PLL enabled before the loader finished");
   strobe_level_a: assert property (take |-> host_strobe_pin == straps.strobe_hi)
      else $error("data taken on the wrong strobe level");
   width_count_a: assert property (
      cnt_reg <= (straps.width8 ? LAST_BYTE : LAST_WORD))
      else $error("group length does not match host width");
   polled_boot_a: assert property (
      state_reg == ST_HOST && !in_reset ##1 state_reg == ST_HOST |-> polled_reg)
      else $error("host boot not in polled mode");
   word_order_a: assert property (
      take && piece_last && !straps.width8 && !in_reset |=>
         group_reg[WORD_W-1:0] == $past(host_parallel_port)
         && group_reg[GW-1:WORD_W] == $past(acc_reg[GW-WORD_W-1:0]) && group_ready_reg)
      else $error("last word not placed least significant");
   i2c_route_a: assert property (
      state_reg == ST_I2C && !in_reset |=> i2c_sel_reg && i2c_master_reg)
      else $error("I2C boot without pin routing or master mode");
   ready_hold_a: assert property (
      group_ready_reg && !group_ack && !in_reset |=> group_ready_reg && $stable(group_reg))
      else $error("pending group lost before acknowledge");

   host_group_c: cover property (take && piece_last && !straps.width8);
   byte_group_c: cover property (take && piece_last && straps.width8);
   i2c_run_c: cover property (state_reg == ST_I2C ##1 state_reg == ST_RUN);
   pll_on_c: cover property ($fell(pll_bypass_reg));

endmodule
`default_nettype wire

// file: tb/rsb_host_model.sv
/*
 * Host processor model for the host port boot path: polls the receive-full flag,
 * then writes one boot group as four words or eight bytes, most significant first.
 * Assumes the bench raises go only while the device sits in host boot.
 */
`timescale 1ns/100ps
`default_nettype none
module rsb_host_model
   import rsb_pkg::*;
(
   input wire logic core_clk,           // Core clock
   input wire logic go,                 // Start one group
   input wire logic [63:0] group_in,    // Group to send
   input wire logic width8,             // Byte mode
   input wire logic strobe_hi,          // Strobe active level
   input wire logic polled,             // Device polls the port
   input wire logic rx_full,            // Device cannot take data
   output logic [HOST_WORD_W-1:0] data, // Host data pins
   output logic strobe_pin,             // Write strobe
   output logic done                    // Group sent, held until next go
);
   logic act;
   int pieces;
   int wait_cnt;
   logic [7:0] piece8;

   assign strobe_pin = strobe_hi ? act : ~act;

   initial begin
      act = 1'b0;
      data = 16'h0;
      done = 1'b0;
      forever begin
         @(posedge core_clk);
         if (go) begin
            done = 1'b0;
            #1;
            pieces = width8 ? 2 * GROUP_WORDS : GROUP_WORDS;
            for (int i = 0; i < pieces; i++) begin
               wait_cnt = 0;
               // Polled handshake only, no interrupt or DMA request
               while ((!polled || rx_full) && wait_cnt < 200) begin
                  @(posedge core_clk);
                  #1;
                  wait_cnt++;
               end
               piece8 = group_in[63-8*i -: 8];
               if (width8) begin
                  data = {~piece8, piece8};
               end else begin
                  data = group_in[63-16*i -: 16];
               end
               act = 1'b1;
               @(posedge core_clk);
               #1;
               act = 1'b0;
               // No pull on these lines, so a released bus shows the inverse
               data = ~data;
               @(posedge core_clk);
               #1;
            end
            done = 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// file: tb/reset_strap_boot_select_tb.sv
/*
 * Self-checking bench for the boot controller: strap decode table, then hard reset,
 * host boot groups in both widths and the PLL bypass sequence.
 * Assumes the host model in rsb_host_model.sv and the design package.
 */
`timescale 1ns/100ps
`default_nettype none
module reset_strap_boot_select_tb
   import rsb_pkg::*;
;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic por_n = 1'b0;
   logic hard_n = 1'b1;
   logic [1:0] sel = 2'h0;
   logic wd = 1'b0;
   logic pol = 1'b0;
   logic w8 = 1'b0;
   logic sty = 1'b0;
   logic loader_done = 1'b0;
   logic pll_req = 1'b0;
   logic ack = 1'b0;
   logic go = 1'b0;
   logic m_hi = 1'b0;
   logic m_w8 = 1'b0;
   logic [63:0] grp = 64'h0;
   logic [15:0] hdata;
   logic hstrobe, done, core_in_reset, core_running, watchdog_enable, host_strobe_high;
   logic host_8bit, host_strobe_dual, pll_bypass, host_polled_mode, host_dma_enable;
   logic host_rx_full, group_ready, i2c_pins_select, i2c_master, boot_reserved_err;
   logic [63:0] group_data;
   int fail_count = 0;
   int check_count = 0;
   logic [5:0] row_in [4] = '{6'h0a, 6'h15, 6'h2f, 6'h30};
   logic [6:0] row_exp [4] = '{7'h54, 7'h2a, 7'h7c, 7'h01};

   always #12.5 core_clk = ~core_clk;

   rsb_boot_ctrl dut (
      .core_clk(core_clk), .srst(srst), .power_on_reset_n(por_n), .hard_reset_n(hard_n),
      .boot_source_select(sel), .watchdog_strap(wd), .host_strobe_polarity(pol),
      .host_width_select(w8), .host_strobe_style(sty), .host_parallel_port(hdata),
      .host_strobe_pin(hstrobe), .loader_done(loader_done), .pll_enable_req(pll_req),
      .group_ack(ack), .core_in_reset(core_in_reset), .core_running(core_running),
      .watchdog_enable(watchdog_enable), .host_strobe_high(host_strobe_high),
      .host_8bit(host_8bit), .host_strobe_dual(host_strobe_dual), .pll_bypass(pll_bypass),
      .host_polled_mode(host_polled_mode), .host_dma_enable(host_dma_enable),
      .host_rx_full(host_rx_full), .group_data(group_data), .group_ready(group_ready),
      .i2c_pins_select(i2c_pins_select), .i2c_master(i2c_master),
      .boot_reserved_err(boot_reserved_err)
   );

   rsb_host_model host (
      .core_clk(core_clk), .go(go), .group_in(grp), .width8(m_w8), .strobe_hi(m_hi),
      .polled(host_polled_mode), .rx_full(host_rx_full), .data(hdata),
      .strobe_pin(hstrobe), .done(done)
   );

   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   // Straps only count at the release edge, so they are set while reset is low
   task automatic por(input logic [5:0] s);
      por_n = 1'b0;
      {sel, wd, pol, w8, sty} = s;
      m_hi = s[2];
      m_w8 = s[1];
      step(2);
      por_n = 1'b1;
      step(3);
   endtask

   task automatic hard_pulse;
      hard_n = 1'b0;
      step(2);
      check({core_in_reset, host_polled_mode, pll_bypass}, 3'h5);
      hard_n = 1'b1;
      step(2);
   endtask

   task automatic send(input logic [63:0] g);
      int k;
      grp = g;
      go = 1'b1;
      step(1);
      go = 1'b0;
      k = 0;
      while (!done && k < 200) begin
         step(1);
         k++;
      end
      if (!done) begin
         fail_count++;
         wrap_up();
      end
   endtask

   initial begin
      #500000;
      fail_count++;
      wrap_up();
   end

   initial begin
      step(3);
      srst = 1'b0;
      for (int r = 0; r < 4; r++) begin
         por(row_in[r]);
         check({watchdog_enable, host_strobe_high, host_8bit, host_strobe_dual,
                host_polled_mode, i2c_master, boot_reserved_err}, row_exp[r]);
         check({pll_bypass, host_dma_enable, core_in_reset, core_running, i2c_pins_select},
               {4'h8, row_exp[r][1]});
      end
      // I2C boot runs to completion without touching the PLL
      por(6'h10);
      loader_done = 1'b1;
      step(1);
      loader_done = 1'b0;
      step(1);
      check({core_running, i2c_pins_select, i2c_master, pll_bypass}, 4'hf);
      por(6'h0c);
      // Pins move after capture; outputs must keep the captured set
      {sel, wd, pol, w8, sty} = 6'h33;
      step(2);
      check({watchdog_enable, host_strobe_high, host_8bit, host_strobe_dual}, 4'hc);
      hard_pulse();
      check({watchdog_enable, host_strobe_high, host_8bit, host_strobe_dual,
             host_polled_mode, core_in_reset}, 6'h32);
      send(64'h0123_4567_89ab_cdef);
      check(group_data, 64'h0123_4567_89ab_cdef);
      check({group_ready, host_rx_full}, 2'h3);
      ack = 1'b1;
      step(1);
      ack = 1'b0;
      step(1);
      check({group_ready, host_rx_full}, 2'h0);
      pll_req = 1'b1;
      step(2);
      pll_req = 1'b0;
      check(pll_bypass, 1'b1);
      loader_done = 1'b1;
      step(1);
      loader_done = 1'b0;
      step(2);
      check({core_running, host_polled_mode, pll_bypass, host_dma_enable}, 4'ha);
      pll_req = 1'b1;
      step(1);
      pll_req = 1'b0;
      step(1);
      check(pll_bypass, 1'b0);
      por(6'h22);
      hard_pulse();
      check({pll_bypass, host_strobe_high, host_8bit, host_polled_mode}, 4'hb);
      send(64'hfedc_ba98_7654_3210);
      check(group_data, 64'hfedc_ba98_7654_3210);
      loader_done = 1'b1;
      step(1);
      loader_done = 1'b0;
      step(2);
      check({core_running, pll_bypass}, 2'h2);
      wrap_up();
   end
endmodule
`default_nettype wire
